// file: logic/ctm_consts.svh
// Purpose: offsets, field positions, reset values of the compact timer
// Assumes: 32-bit AHB-Lite words, one register per aligned word
// Notes: definitions only
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH
`define CTM_OFS_CTRL0 8'h00
`define CTM_OFS_CTRL1 8'h04
`define CTM_OFS_CNT_LO 8'h08
`define CTM_OFS_CNT_HI 8'h0C
`define CTM_OFS_CMPA_LO 8'h10
`define CTM_OFS_CMPA_HI 8'h14
`define CTM_OFS_PERIOD 8'h18
`define CTM_OFS_FLAGS 8'h1C
`define CTM_OFS_TICK 8'h20
`define CTM_CTRL0_ON_BIT 3
`define CTM_CTRL1_MODE_HI 7
`define CTM_CTRL1_MODE_LO 6
`define CTM_CTRL1_ACT_HI 5
`define CTM_CTRL1_ACT_LO 4
`define CTM_CTRL1_INIT_BIT 3
`define CTM_CTRL1_INV_BIT 2
`define CTM_CTRL1_SWAP_BIT 1
`define CTM_CTRL1_CLR_BIT 0
`define CTM_FLAG_A_BIT 0
`define CTM_FLAG_P_BIT 1
`define CTM_BYTE_RESET 8'h00
`define CTM_COUNT_MAX 16'hFFFF
`endif

// file: logic/ctm_pkg.sv
// Purpose: types shared by the compact timer files
// Assumes: nothing
// Notes: mode codes follow the two-bit mode field
package ctm_pkg;
    typedef enum logic [1:0] {
        CTM_MODE_CMP = 2'b00,
        CTM_MODE_UNDEF = 2'b01,
        CTM_MODE_PWM = 2'b10,
        CTM_MODE_TMR = 2'b11
    } ctm_mode_e;
    typedef enum logic [1:0] {
        CTM_ACT_NONE = 2'b00,
        CTM_ACT_LOW = 2'b01,
        CTM_ACT_HIGH = 2'b10,
        CTM_ACT_TOGGLE = 2'b11
    } ctm_action_e;
    typedef logic [15:0] ctm_count_t;
    typedef logic [7:0] ctm_byte_t;
endpackage

// file: logic/ctm_compare.sv
// Purpose: comparator A, comparator P and overflow detection
// Assumes: count and compare values stable within a cycle
// Notes: purely combinational
`timescale 1ns/1ps
`include "ctm_consts.svh"
module ctm_compare
    import ctm_pkg::*;
(
    input wire ctm_pkg::ctm_count_t count,
    input wire ctm_pkg::ctm_count_t full_compare_value,
    input wire ctm_pkg::ctm_byte_t period_compare_value,
    output logic hit_a,
    output logic hit_p,
    output logic at_max
);
    // top byte only; match on the last count so the clear makes 256 x value
    logic [7:0] top_next;
    assign top_next = count[15:8] + 8'h01;
    assign hit_p = (top_next == period_compare_value) && (count[7:0] == 8'hFF) &&
        (period_compare_value != 8'h00);
    // zero compare value never flags, counter overflows instead
    assign hit_a = (count == full_compare_value) && (full_compare_value != 16'h0000);
    assign at_max = (count == `CTM_COUNT_MAX);
endmodule

// file: logic/ctm_pin.sv
// Purpose: timer output pin level control
// Assumes: events are one-cycle pulses
// Notes: level held in a flip-flop, inversion registered too
`timescale 1ns/1ps
`include "ctm_consts.svh"
module ctm_pin
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmp_mode,
    input wire logic start,
    input wire logic match_a,
    input wire logic [1:0] action,
    input wire logic output_initial_level,
    output logic level
);
    import ctm_pkg::*;
    logic level_q;
    logic level_d;
    ctm_action_e act;
    assign act = ctm_action_e'(action);
    always_comb
    begin
        level_d = level_q;
        if (cmp_mode && start)
        begin
            level_d = output_initial_level;
        end
        else if (cmp_mode && match_a)
        begin
            case (act)
                CTM_ACT_LOW: level_d = 1'b0;
                CTM_ACT_HIGH: level_d = 1'b1;
                CTM_ACT_TOGGLE: level_d = ~level_q;
                default: level_d = level_q;
            endcase
        end
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            level_q <= 1'b0;
        else
            level_q <= level_d;
    end
    assign level = level_q;
    pin_init_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmp_mode && start) |=> (level_q == $past(output_initial_level)))
        else $error("pin not set to initial level on start");
    pin_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!start && !match_a) |=> $stable(level_q))
        else $error("pin changed without a comparator A match");
endmodule

// file: logic/ctm_top.sv
// Purpose: compact 16-bit timer with two comparators behind AHB-Lite
// Assumes: single word transfers, zero wait states, OKAY always
// Notes: count_tick gates the counting clock; pwm waveform not built
//
// Summary of operation
// - invert bit inverts pin, not timer mode
// - swap bit exchanges period and duty roles
// - clear select: A match, else P/overflow
// - overflow clear only when period value zero
// - clear select ignored in pwm mode
// - counter read as two zero-reset bytes
// - compare A held in two rw bytes
// - period value compared with counter top byte
// - mode 00 compare output, 11 timer
// - P clear raises the P flag, not the A flag
// - A clear outside pwm mode raises only the A flag
// - A clear, zero value: overflow, no flag
// - pin level changes only on comparator A match or counter-on rise
// - action field sets, clears, toggles or holds
// - counter-on rise loads initial pin level
// - timer mode counts alike, pin released
// - action codes 00 hold 01 low 10 high 11 toggle
// - initial level bit picks pin start level
// - counter-on rise zeroes, fall freezes counter
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ctm_consts.svh"
module ctm_top
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic count_tick,
    output logic timer_output_pin,
    output logic timer_output_oe_n
);
    import ctm_pkg::*;
    ////////////////////////////////////////////////////////////////////
    // bus slave
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    ctm_byte_t cmpa_lo_q;
    ctm_byte_t cmpa_hi_q;
    ctm_byte_t period_q;
    logic [1:0] flags_q;
    logic tick_en_q;
    wire addr_ok = hsel && hready && htrans[1];
    wire rd_req = addr_ok && !hwrite;
    wire wr_req = addr_ok && hwrite;
    wire [7:0] req_addr = haddr[7:0];
    wire wr_ctrl0 = wr_pend_q && (wr_addr_q == `CTM_OFS_CTRL0);
    wire wr_ctrl1 = wr_pend_q && (wr_addr_q == `CTM_OFS_CTRL1);
    wire wr_cmpa_lo = wr_pend_q && (wr_addr_q == `CTM_OFS_CMPA_LO);
    wire wr_cmpa_hi = wr_pend_q && (wr_addr_q == `CTM_OFS_CMPA_HI);
    wire wr_period = wr_pend_q && (wr_addr_q == `CTM_OFS_PERIOD);
    wire wr_flags = wr_pend_q && (wr_addr_q == `CTM_OFS_FLAGS);
    wire wr_tick = wr_pend_q && (wr_addr_q == `CTM_OFS_TICK);
    ////////////////////////////////////////////////////////////////////
    // control fields
    wire counter_on = ctrl0_q[`CTM_CTRL0_ON_BIT];
    wire [1:0] op_mode = {ctrl1_q[`CTM_CTRL1_MODE_HI], ctrl1_q[`CTM_CTRL1_MODE_LO]};
    wire [1:0] output_action = {ctrl1_q[`CTM_CTRL1_ACT_HI], ctrl1_q[`CTM_CTRL1_ACT_LO]};
    wire output_initial_level = ctrl1_q[`CTM_CTRL1_INIT_BIT];
    wire output_invert = ctrl1_q[`CTM_CTRL1_INV_BIT];
    wire pwm_role_swap = ctrl1_q[`CTM_CTRL1_SWAP_BIT];
    wire clear_source_select = ctrl1_q[`CTM_CTRL1_CLR_BIT];
    ctm_mode_e mode;
    assign mode = ctm_mode_e'(op_mode);
    wire cmp_mode = (mode == CTM_MODE_CMP);
    wire tmr_mode = (mode == CTM_MODE_TMR);
    wire pwm_mode = (mode == CTM_MODE_PWM);
    ////////////////////////////////////////////////////////////////////
    // counter
    ctm_count_t count_q;
    ctm_count_t count_d;
    logic on_prev_q;
    wire on_rise = counter_on && !on_prev_q;
    wire ctr_step = counter_on && !on_rise && (tick_en_q ? count_tick : 1'b1);
    ctm_count_t full_compare_value;
    assign full_compare_value = {cmpa_hi_q, cmpa_lo_q};
    logic hit_a;
    logic hit_p;
    logic at_max;
    ctm_compare u_compare (
        .count(count_q),
        .full_compare_value(full_compare_value),
        .period_compare_value(period_q),
        .hit_a(hit_a),
        .hit_p(hit_p),
        .at_max(at_max)
    );
    // pwm: period comes from P unless roles swapped
    wire clr_by_a = pwm_mode ? pwm_role_swap : clear_source_select;
    wire match_a = ctr_step && hit_a;
    wire match_p = ctr_step && hit_p && !(clr_by_a && !pwm_mode);
    wire p_clear = ctr_step && !clr_by_a && (hit_p || (at_max && period_q == 8'h00));
    wire a_clear = ctr_step && clr_by_a && hit_a;
    always_comb
    begin
        count_d = count_q;
        if (on_rise)
            count_d = 16'h0000;
        else if (a_clear || p_clear)
            count_d = 16'h0000;
        else if (ctr_step)
            count_d = count_q + 16'h0001;
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 16'h0000;
            on_prev_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            on_prev_q <= counter_on;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // match flags: set wins over software clear
    logic [1:0] flag_set;
    assign flag_set = {match_p, match_a};
    wire [1:0] flag_clr = wr_flags ? hwdata[1:0] : 2'b00;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_q <= 2'b00;
        else
            flags_q <= flag_set | (flags_q & ~flag_clr);
    end
    wire match_a_flag = flags_q[`CTM_FLAG_A_BIT];
    wire match_p_flag = flags_q[`CTM_FLAG_P_BIT];
    ////////////////////////////////////////////////////////////////////
    // output pin
    logic pin_level;
    ctm_pin u_pin (
        .clk(clk),
        .reset_n(reset_n),
        .cmp_mode(cmp_mode),
        .start(on_rise),
        .match_a(match_a),
        .action(output_action),
        .output_initial_level(output_initial_level),
        .level(pin_level)
    );
    logic pin_q;
    logic oe_n_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end
        else
        begin
            pin_q <= pin_level ^ output_invert;
            oe_n_q <= !cmp_mode;
        end
    end
    assign timer_output_pin = pin_q;
    assign timer_output_oe_n = oe_n_q;
    ////////////////////////////////////////////////////////////////////
    // register writes and read data
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl0_q <= `CTM_BYTE_RESET;
            ctrl1_q <= `CTM_BYTE_RESET;
            cmpa_lo_q <= `CTM_BYTE_RESET;
            cmpa_hi_q <= `CTM_BYTE_RESET;
            period_q <= `CTM_BYTE_RESET;
            tick_en_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl0)
                ctrl0_q <= hwdata[7:0] & 8'hF8;
            if (wr_ctrl1)
                ctrl1_q <= hwdata[7:0];
            if (wr_cmpa_lo)
                cmpa_lo_q <= hwdata[7:0];
            if (wr_cmpa_hi)
                cmpa_hi_q <= hwdata[7:0];
            if (wr_period)
                period_q <= hwdata[7:0];
            if (wr_tick)
                tick_en_q <= hwdata[0];
        end
    end
    logic [7:0] rd_byte;
    always_comb
    begin
        case (req_addr)
            `CTM_OFS_CTRL0: rd_byte = ctrl0_q;
            `CTM_OFS_CTRL1: rd_byte = ctrl1_q;
            `CTM_OFS_CNT_LO: rd_byte = count_q[7:0];
            `CTM_OFS_CNT_HI: rd_byte = count_q[15:8];
            `CTM_OFS_CMPA_LO: rd_byte = cmpa_lo_q;
            `CTM_OFS_CMPA_HI: rd_byte = cmpa_hi_q;
            `CTM_OFS_PERIOD: rd_byte = period_q;
            `CTM_OFS_FLAGS: rd_byte = {6'h00, match_p_flag, match_a_flag};
            `CTM_OFS_TICK: rd_byte = {7'h00, tick_en_q};
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= wr_req;
            if (wr_req)
                wr_addr_q <= req_addr;
            if (rd_req)
                rdata_q <= {24'h000000, rd_byte};
        end
    end
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    ////////////////////////////////////////////////////////////////////
    // checks
    sequence on_rising_s;
        counter_on && !on_prev_q;
    endsequence
    on_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        on_rising_s |=> (count_q == 16'h0000))
        else $error("counter not zeroed on start");
    off_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!counter_on && on_prev_q) ##1 !counter_on |-> $stable(count_q))
        else $error("counter moved while off");
    a_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
        (a_clear && !on_rise) |=> (count_q == 16'h0000 && match_a_flag))
        else $error("A match did not clear counter");
    no_pflag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clear_source_select && !pwm_mode && !flags_q[1]) |=> !match_p_flag)
        else $error("P flag raised with A clear");
    ovf_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ctr_step && !clr_by_a && at_max && period_q == 8'h00) |=> count_q == 16'h0000)
        else $error("overflow clear missing");
    zero_a_a: assert property (@(posedge clk) disable iff (!reset_n)
        (full_compare_value == 16'h0000) |-> !match_a)
        else $error("A flag with zero compare");
    p_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        match_p |-> (count_q[7:0] == 8'hFF && (count_q[15:8] + 8'h01) == period_q))
        else $error("P match off the 256 grid");
    tmr_free_a: assert property (@(posedge clk) disable iff (!reset_n)
        tmr_mode |=> timer_output_oe_n)
        else $error("pin driven in timer mode");
    inv_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 (timer_output_pin == ($past(pin_level) ^ $past(output_invert))))
        else $error("pin polarity wrong");
    ////////////////////////////////////////////////////////////////////
    // clear, flag, pin and bus checks
    wire [7:0] count_lo_byte = count_q[7:0];
    wire [7:0] count_hi_byte = count_q[15:8];
    sequence a_hit_s;
        cmp_mode && match_a;
    endsequence
    sequence pwm_step_s;
        pwm_mode && ctr_step;
    endsequence
    p_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
        p_clear |=> (count_q == 16'h0000))
        else $error("P match did not clear counter");
    per_end_a: assert property (@(posedge clk) disable iff (!reset_n)
        (p_clear && period_q != 8'h00) |-> (count_q == {period_q - 8'h01, 8'hFF}))
        else $error("P clear not at end of period");
    swap_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        pwm_step_s ##0 (!pwm_role_swap && hit_a && !hit_p && !at_max)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("A match cleared with roles not swapped");
    swap_one_a: assert property (@(posedge clk) disable iff (!reset_n)
        pwm_step_s ##0 (pwm_role_swap && hit_p && !hit_a)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("P match cleared with roles swapped");
    pflag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        match_p |=> match_p_flag)
        else $error("P flag not raised");
    aflag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        match_a |=> match_a_flag)
        else $error("A flag not raised");
    act_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        a_hit_s ##0 (output_action == 2'b01) |=> !pin_level)
        else $error("pin not driven low on A match");
    act_high_a: assert property (@(posedge clk) disable iff (!reset_n)
        a_hit_s ##0 (output_action == 2'b10) |=> pin_level)
        else $error("pin not driven high on A match");
    act_tog_a: assert property (@(posedge clk) disable iff (!reset_n)
        a_hit_s ##0 (output_action == 2'b11) |=> (pin_level != $past(pin_level)))
        else $error("pin not toggled on A match");
    act_none_a: assert property (@(posedge clk) disable iff (!reset_n)
        a_hit_s ##0 (output_action == 2'b00) |=> $stable(pin_level))
        else $error("pin changed with no action");
    pin_p_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cmp_mode && match_p && !match_a) |=> $stable(pin_level))
        else $error("P match moved the pin");
    cmp_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmp_mode |=> !timer_output_oe_n)
        else $error("pin not driven in compare mode");
    oe_pwm_a: assert property (@(posedge clk) disable iff (!reset_n)
        pwm_mode |=> timer_output_oe_n)
        else $error("pin driven in pwm mode");
    cnt_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ctr_step && !a_clear && !p_clear) |=> (count_q == $past(count_q) + 16'h0001))
        else $error("counter did not step");
    tick_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!ctr_step && counter_on && on_prev_q) |=> $stable(count_q))
        else $error("counter moved without a step");
    off_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        !counter_on |-> (!match_a && !match_p))
        else $error("match while counter off");
    a_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ctr_step && clr_by_a && at_max) |=> (count_q == 16'h0000))
        else $error("counter did not overflow at maximum");
    lo_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_cmpa_lo |=> ({24'h000000, cmpa_lo_q} == ($past(hwdata) & 32'h000000FF)))
        else $error("compare low byte not written");
    hi_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_cmpa_hi |=> ({24'h000000, cmpa_hi_q} == ($past(hwdata) & 32'h000000FF)))
        else $error("compare high byte not written");
    rd_lo_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_req && req_addr == `CTM_OFS_CNT_LO) |=> (hrdata == {24'h000000, $past(count_lo_byte)}))
        else $error("count low byte read wrong");
    rd_hi_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_req && req_addr == `CTM_OFS_CNT_HI) |=> (hrdata == {24'h000000, $past(count_hi_byte)}))
        else $error("count high byte read wrong");
endmodule

// file: testbench/ctm_tb.sv
// Purpose: self-checking bench for the compact timer
// Assumes: zero-wait AHB-Lite slave, byte data in bits 7:0
// Notes: counter counts every clk unless tick gating is on
`timescale 1ns/1ps
`include "ctm_consts.svh"
`define CHK(nm, got, exp) \
begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
        n_mismatch++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module compact_timer_compare_match_tb;
    import ctm_pkg::*;
    localparam logic [7:0] o_c0 = `CTM_OFS_CTRL0, o_c1 = `CTM_OFS_CTRL1, o_lo = `CTM_OFS_CNT_LO;
    localparam logic [7:0] o_hi = `CTM_OFS_CNT_HI, o_al = `CTM_OFS_CMPA_LO, o_ah = `CTM_OFS_CMPA_HI;
    localparam logic [7:0] o_p = `CTM_OFS_PERIOD, o_f = `CTM_OFS_FLAGS, o_t = `CTM_OFS_TICK;
    localparam logic [7:0] on_v = 8'h01 << `CTM_CTRL0_ON_BIT;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h00000000;
    logic count_tick = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic timer_output_pin;
    logic timer_output_oe_n;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    ctm_top u_ctm_top (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .count_tick(count_tick), .timer_output_pin(timer_output_pin),
        .timer_output_oe_n(timer_output_oe_n));

    ////////////////////////////////////////////////////////////////////////////////
    task waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one single word transfer, address phase then data phase
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h000000, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
        `CHK("hresp", hresp, 1'b0)
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task rdv(input logic [7:0] a, output logic [7:0] v);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        v = r[7:0];
    endtask

    task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        `CHK(nm, r, {24'h000000, e})
    endtask

    function automatic logic [7:0] c1(input ctm_mode_e m, input logic [1:0] act,
        input logic init, input logic inv, input logic clr);
        return {m, act, init, inv, 1'b0, clr};
    endfunction

    task cfg(input logic [15:0] a, input logic [7:0] p);
        wr(o_al, a[7:0]);
        wr(o_ah, a[15:8]);
        wr(o_p, p);
    endtask

    // stop, set control, clear flags, then counter-on rising edge
    task start(input logic [7:0] ctl);
        wr(o_c0, 8'h00);
        wr(o_c1, ctl);
        wr(o_f, 8'h03);
        wr(o_c0, on_v);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset();
        `CHK("pin_rst", timer_output_pin, 1'b0)
        rd("ctrl0", o_c0, 8'h00);
        rd("ctrl1", o_c1, 8'h00);
        rd("cnt_lo", o_lo, 8'h00);
        rd("cnt_hi", o_hi, 8'h00);
        rd("cmpa_lo", o_al, 8'h00);
        rd("cmpa_hi", o_ah, 8'h00);
        rd("period", o_p, 8'h00);
        wr(o_lo, 8'hAA);
        rd("cnt_ro", o_lo, 8'h00);
        wr(8'h3C, 8'h5A);
        rd("unmapped", 8'h3C, 8'h00);
        cfg(16'h5AA5, 8'h3C);
        rd("cmpa_lo_rw", o_al, 8'hA5);
        rd("cmpa_hi_rw", o_ah, 8'h5A);
        rd("period_rw", o_p, 8'h3C);
    endtask

    // one match per action code; init level is the inverse of act[1]
    task t_actions();
        logic [3:0] exp_pin;
        exp_pin = 4'b1101;
        cfg(16'h0040, 8'h00);
        for (int a = 0; a < 4; a++)
        begin
            start(c1(CTM_MODE_CMP, a[1:0], ~a[1], 1'b0, 1'b0));
            waitc(4);
            `CHK("pin_init", timer_output_pin, ~a[1])
            `CHK("oe_cmp", timer_output_oe_n, 1'b0)
            waitc(100);
            `CHK("pin_act", timer_output_pin, exp_pin[a])
            rd("flag_a", o_f, 8'h01);
        end
        wr(o_c1, c1(CTM_MODE_CMP, 2'b11, 1'b0, 1'b1, 1'b0));
        waitc(3);
        `CHK("pin_inv", timer_output_pin, 1'b0)
        wr(o_c1, c1(CTM_MODE_TMR, 2'b11, 1'b0, 1'b1, 1'b0));
        waitc(3);
        `CHK("oe_tmr", timer_output_oe_n, 1'b1)
    endtask

    // period match clears at 256 counts and leaves the pin alone
    task t_pclear();
        logic [7:0] v;
        cfg(16'h1000, 8'h01);
        start(c1(CTM_MODE_CMP, 2'b11, 1'b0, 1'b0, 1'b0));
        waitc(300);
        `CHK("pin_p", timer_output_pin, 1'b0)
        wr(o_c0, 8'h00);
        rd("hi_p", o_hi, 8'h00);
        rd("flag_p", o_f, 8'h02);
        rdv(o_lo, v);
        waitc(5);
        rd("frozen", o_lo, v);
    endtask

    task t_aclear();
        cfg(16'h0180, 8'h01);
        start(c1(CTM_MODE_TMR, 2'b10, 1'b0, 1'b0, 1'b1));
        waitc(500);
        `CHK("oe_tmr2", timer_output_oe_n, 1'b1)
        wr(o_c0, 8'h00);
        rd("hi_a", o_hi, 8'h00);
        rd("flag_only_a", o_f, 8'h01);
    endtask

    // pwm: the swap bit alone picks the clearing comparator
    task t_pwm();
        cfg(16'h0180, 8'h01);
        start(c1(CTM_MODE_PWM, 2'b00, 1'b0, 1'b0, 1'b1));
        waitc(300);
        wr(o_c0, 8'h00);
        rd("hi_pwm_p", o_hi, 8'h00);
        rd("flag_pwm_p", o_f, 8'h02);
        start(c1(CTM_MODE_PWM, 2'b00, 1'b0, 1'b0, 1'b0) | 8'h02);
        waitc(300);
        wr(o_c0, 8'h00);
        rd("hi_pwm_a", o_hi, 8'h01);
        rd("flag_pwm_a", o_f, 8'h02);
    endtask

    // zero compare values: no clear before overflow, no A flag
    task t_overflow();
        logic [7:0] v;
        cfg(16'h0000, 8'h00);
        for (int c = 0; c < 2; c++)
        begin
            start(c1(CTM_MODE_CMP, 2'b11, 1'b0, 1'b0, c[0]));
            waitc(400);
            wr(o_c0, 8'h00);
            rd("hi_ovf", o_hi, 8'h01);
            rd("flag_none", o_f, 8'h00);
            `CHK("pin_ovf", timer_output_pin, 1'b0)
        end
        wr(o_c0, on_v);
        wr(o_c0, 8'h00);
        rd("hi_restart", o_hi, 8'h00);
        rdv(o_lo, v);
        `CHK("lo_restart", v < 8'h08, 1'b1)
    endtask

    task t_tick();
        logic [7:0] v;
        wr(o_t, 8'h01);
        start(c1(CTM_MODE_TMR, 2'b00, 1'b0, 1'b0, 1'b0));
        waitc(50);
        rd("tick_hold", o_lo, 8'h00);
        count_tick <= 1'b1;
        waitc(10);
        count_tick <= 1'b0;
        wr(o_c0, 8'h00);
        rdv(o_lo, v);
        `CHK("tick_run", v != 8'h00, 1'b1)
        wr(o_t, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task results();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        waitc(30000);
        n_mismatch++;
        results();
    end

    initial
    begin
        waitc(10);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_actions();
        t_pclear();
        t_aclear();
        t_pwm();
        t_overflow();
        t_tick();
        results();
    end
endmodule
